// ==== inc/dmh_params.svh ====
// Offsets, field positions, reset values and timing counts of the DMA channel block
`ifndef DMH_PARAMS_SVH
`define DMH_PARAMS_SVH

// Register group bases and per-channel offsets
`define DMH_CH0_BASE        32'h0050_0000
`define DMH_CH1_BASE        32'h0050_0008
`define DMH_OFF_ABORT       3'h0
`define DMH_OFF_ADDR_HI     3'h0
`define DMH_OFF_ADDR_LO     3'h2
`define DMH_OFF_COUNT       3'h4
`define DMH_OFF_CTRL        3'h6
`define DMH_OFF_STATUS      3'h6

// Control field positions
`define DMH_CTL_IE          0
`define DMH_CTL_WORD        1
`define DMH_CTL_OUT         2
`define DMH_CTL_PRI         3
`define DMH_CTL_W           7

// Status field positions
`define DMH_STS_ARM         0
`define DMH_STS_INT         1

// Reset values and the count left after the last transfer
`define DMH_CTL_RST         7'h00
`define DMH_CNT_RST         16'h0000
`define DMH_ADDR_RST        32'h0000_0000
`define DMH_CNT_DONE        16'hFFFF

// Timing, figures in ns and derived cycle counts
`define DMH_CLK_NS          40
`define DMH_PRI0_WIN_NS     65
`define DMH_PRI1_WIN_NS     1600
`define DMH_CARD_TO_NS      5000
`define DMH_MEM_TO_NS       3000
`define DMH_DN(t)           (((t) / `DMH_CLK_NS) < 1 ? 1 : ((t) / `DMH_CLK_NS))
`define DMH_UP(t)           (((t) + `DMH_CLK_NS - 1) / `DMH_CLK_NS)
`define DMH_PRI0_WIN_CYC    `DMH_DN(`DMH_PRI0_WIN_NS)
`define DMH_PRI1_WIN_CYC    `DMH_DN(`DMH_PRI1_WIN_NS)
`define DMH_CARD_TO_CYC     `DMH_UP(`DMH_CARD_TO_NS)
`define DMH_MEM_TO_CYC      `DMH_UP(`DMH_MEM_TO_NS)

`endif

// ==== inc/dmh_pkg.sv ====
// Types shared by the DMA channel block
package dmh_pkg;

  typedef enum logic [2:0] {
    dmh_st_idle   = 3'h0,
    dmh_st_busreq = 3'h1,
    dmh_st_mem    = 3'h2,
    dmh_st_card   = 3'h3,
    dmh_st_end    = 3'h4,
    dmh_st_hold   = 3'h5
  } dmh_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] cnt;
    logic [6:0]  ctl;
    logic        arm;
    logic        intr;
  } dmh_chan_t;

  typedef struct packed {
    logic        req;
    logic        rnw;
    logic [31:0] addr;
    logic        uds_n;
    logic        lds_n;
    logic [15:0] wdata;
  } dmh_host_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } dmh_host_rsp_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic        drive_n;
    logic        as_n;
    logic        rnw;
    logic        uds_n;
    logic        lds_n;
    logic        long_n;
    logic [15:0] data;
    logic        data_oe_n;
  } dmh_bus_out_t;

endpackage

// ==== rtl/dmh_fifo.sv ====
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dmh_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         flush_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_chk
      $error("dmh_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } dmh_fifo_st_t;

  dmh_fifo_st_t q;
  dmh_fifo_st_t n;
  logic [AW:0]  fill;

  assign fill        = q.wp - q.rp;
  assign in_ready_o  = fill != (AW+1)'(DEPTH);
  assign out_valid_o = fill != '0;
  assign out_data_o  = q.mem[q.rp[AW-1:0]];

  always_comb
  begin
    n = q;
    if (in_valid_i && in_ready_o)
    begin
      n.mem[q.wp[AW-1:0]] = in_data_i;
      n.wp = q.wp + 1'b1;
    end
    if (out_valid_o && out_ready_i)
      n.rp = q.rp + 1'b1;
    if (flush_i)
    begin
      n.wp = '0;
      n.rp = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '0;
    else
      q <= n;
  end
endmodule

// ==== rtl/dmh_ctrl.sv ====
// Two-channel DMA controller: card handshake, bus hold and legacy registers
`timescale 1ns/10ps
`include "dmh_params.svh"
module dmh_ctrl #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  // Host register access
  input  wire dmh_pkg::dmh_host_req_t host_req_i,
  output dmh_pkg::dmh_host_rsp_t      host_rsp_o,
  output logic                        irq_o,
  // System bus, controller as master
  input  wire logic                   bus_grant_i,
  input  wire logic                   memory_ack_n_i,
  input  wire logic [15:0]            bus_data_i,
  output dmh_pkg::dmh_bus_out_t       bus_o,
  // I/O card handshake
  input  wire logic [1:0]             xfer_request_n_i,
  output logic [1:0]                  xfer_grant_n_o,
  input  wire logic                   card_data_valid_n_i,
  input  wire logic [15:0]            card_data_i,
  output logic [15:0]                 card_data_o,
  output logic                        card_data_oe_n_o,
  output logic                        fold_n_o,
  output logic                        done_n_o
);
  generate
    if (FIFO_DEPTH < 2)
    begin : g_chk
      $error("dmh_ctrl: FIFO_DEPTH must be at least 2");
    end
  endgenerate

  localparam logic [31:0] BASE     = `DMH_CH0_BASE;
  localparam logic [7:0]  WIN0     = 8'(`DMH_PRI0_WIN_CYC);
  localparam logic [7:0]  WIN1     = 8'(`DMH_PRI1_WIN_CYC);
  localparam logic [7:0]  CARD_TO  = 8'(`DMH_CARD_TO_CYC);
  localparam logic [7:0]  MEM_TO   = 8'(`DMH_MEM_TO_CYC);

  typedef struct packed {
    dmh_pkg::dmh_state_t         st;
    dmh_pkg::dmh_chan_t [1:0]    ch;
    logic                        cur;
    logic                        last;
    logic [7:0]                  tmr;
    logic                        own;
    logic                        data_on;
    dmh_pkg::dmh_bus_out_t       bus;
    logic [1:0]                  grant;
    logic                        fold;
    logic                        done;
    logic [15:0]                 card_dout;
    logic                        card_drive;
    dmh_pkg::dmh_host_rsp_t      rsp;
  } dmh_regs_t;

  dmh_regs_t   q;
  dmh_regs_t   n;
  logic [1:0]  want;
  logic        pick;
  logic        kill;
  logic        f_push;
  logic        f_pop;
  logic        f_flush;
  logic [15:0] f_din;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [15:0] f_dout;
  logic        hch;
  logic [2:0]  off;
  logic        hit;
  logic        bad;

  // Per-channel request qualification and grant pins
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      assign want[gi]           = q.ch[gi].arm && !xfer_request_n_i[gi];
      assign xfer_grant_n_o[gi] = !q.grant[gi];
    end
  endgenerate

  // Priority channel wins over a non-priority one, otherwise rotate
  always_comb
  begin
    if (want == 2'b01)
      pick = 1'b0;
    else if (want == 2'b10)
      pick = 1'b1;
    else if (q.ch[0].ctl[`DMH_CTL_PRI] != q.ch[1].ctl[`DMH_CTL_PRI])
      pick = q.ch[1].ctl[`DMH_CTL_PRI];
    else
      pick = !q.last;
  end

  // Memory lanes of the current transfer: even byte on the upper lane
  function automatic dmh_regs_t set_lanes(dmh_regs_t s);
    dmh_regs_t r;
    r = s;
    r.bus.uds_n = !(s.ch[s.cur].ctl[`DMH_CTL_WORD] || !s.ch[s.cur].addr[0]);
    r.bus.lds_n = !(s.ch[s.cur].ctl[`DMH_CTL_WORD] || s.ch[s.cur].addr[0]);
    return r;
  endfunction

  function automatic dmh_regs_t begin_cycle(dmh_regs_t s);
    dmh_regs_t r;
    logic      out;
    r   = s;
    out = s.ch[s.cur].ctl[`DMH_CTL_OUT];
    r.own          = 1'b1;
    r.bus.drive_n  = 1'b0;
    r.bus.addr     = s.ch[s.cur].addr;
    r.bus.rnw      = out;
    r.bus.as_n     = 1'b0;
    r.bus.long_n   = 1'b1;
    r.grant[s.cur] = 1'b1;
    r.fold = !s.ch[s.cur].ctl[`DMH_CTL_WORD] && !s.ch[s.cur].addr[0];
    r.done = s.ch[s.cur].cnt == 16'h0000;
    r.data_on = 1'b0;
    r.tmr     = 8'h00;
    r.st      = out ? dmh_pkg::dmh_st_mem : dmh_pkg::dmh_st_card;
    if (out)
      r = set_lanes(r);
    return r;
  endfunction

  // Ends the bus cycle; grant, fold and done fall together
  function automatic dmh_regs_t end_cycle(dmh_regs_t s);
    dmh_regs_t r;
    r = s;
    r.bus.as_n      = 1'b1;
    r.bus.uds_n     = 1'b1;
    r.bus.lds_n     = 1'b1;
    r.bus.data_oe_n = 1'b1;
    r.grant         = 2'b00;
    r.fold          = 1'b0;
    r.done          = 1'b0;
    r.card_drive    = 1'b0;
    r.data_on       = 1'b0;
    return r;
  endfunction

  function automatic dmh_regs_t release_bus(dmh_regs_t s);
    dmh_regs_t r;
    r = end_cycle(s);
    r.bus.req     = 1'b0;
    r.bus.drive_n = 1'b1;
    r.own         = 1'b0;
    r.last        = s.cur;
    r.st          = dmh_pkg::dmh_st_idle;
    return r;
  endfunction

  // Bus error: disarm, flag if IE is set, leave address and count untouched
  function automatic dmh_regs_t bus_error(dmh_regs_t s);
    dmh_regs_t r;
    r = release_bus(s);
    r.ch[s.cur].arm  = 1'b0;
    r.ch[s.cur].intr = s.ch[s.cur].intr || s.ch[s.cur].ctl[`DMH_CTL_IE];
    return r;
  endfunction

  always_comb
  begin
    n       = q;
    n.rsp.ack = 1'b0;
    n.rsp.err = 1'b0;
    kill    = 1'b0;
    f_push  = 1'b0;
    f_pop   = 1'b0;
    f_flush = 1'b0;
    f_din   = 16'h0000;
    hch     = host_req_i.addr[3];
    off     = host_req_i.addr[2:0];
    hit     = host_req_i.addr[31:4] == BASE[31:4];
    // Word access on even address; byte read allowed only at status
    bad = !hit
          || (host_req_i.uds_n && host_req_i.lds_n)
          || (!host_req_i.uds_n && !host_req_i.lds_n && off[0])
          || ((host_req_i.uds_n != host_req_i.lds_n)
              && !(host_req_i.rnw && off[2:1] == 2'(`DMH_OFF_STATUS >> 1)));

    // Host register access
    if (host_req_i.req)
    begin
      n.rsp.ack   = 1'b1;
      n.rsp.err   = bad;
      n.rsp.rdata = 16'h0000;
      if (!bad && host_req_i.rnw)
      begin
        unique case (off[2:1])
          2'b00:
          begin
            if (q.ch[hch].arm)
            begin
              n.ch[hch].arm = 1'b0;
              kill = q.cur == hch && q.st != dmh_pkg::dmh_st_idle;
            end
            else
              n.ch[hch].intr = 1'b0;
          end
          2'b01:
            n.rsp.rdata = 16'h0000;
          2'b10:
            n.rsp.rdata = q.ch[hch].cnt;
          2'b11:
          begin
            n.rsp.rdata[`DMH_STS_ARM]     = q.ch[hch].arm;
            n.rsp.rdata[`DMH_STS_INT]     = q.ch[hch].intr;
            n.rsp.rdata[8+`DMH_STS_ARM]   = q.ch[hch].arm;
            n.rsp.rdata[8+`DMH_STS_INT]   = q.ch[hch].intr;
          end
        endcase
      end
      else if (!bad)
      begin
        unique case (off[2:1])
          2'b00: n.ch[hch].addr[31:16] = host_req_i.wdata;
          2'b01: n.ch[hch].addr[15:0]  = host_req_i.wdata;
          2'b10: n.ch[hch].cnt         = host_req_i.wdata;
          2'b11:
          begin
            n.ch[hch].ctl = host_req_i.wdata[`DMH_CTL_W-1:0];
            n.ch[hch].arm = 1'b1;
          end
        endcase
      end
    end

    // Transfer engine
    unique case (q.st)
      dmh_pkg::dmh_st_idle:
      begin
        if (|want)
        begin
          n.cur     = pick;
          n.bus.req = 1'b1;
          n.st      = dmh_pkg::dmh_st_busreq;
        end
      end
      dmh_pkg::dmh_st_busreq:
      begin
        if (!n.ch[q.cur].arm)
          n = release_bus(n);
        else if (bus_grant_i)
          n = begin_cycle(n);
      end
      dmh_pkg::dmh_st_card:
      begin
        n.tmr = q.tmr + 8'h01;
        if (!q.ch[q.cur].ctl[`DMH_CTL_OUT])
        begin
          if (!card_data_valid_n_i && f_in_ready)
          begin
            f_push = 1'b1;
            f_din  = card_data_i;
            n.tmr  = 8'h00;
            n.st   = dmh_pkg::dmh_st_mem;
          end
          else if (q.tmr >= CARD_TO - 8'h01)
            n = bus_error(n);
        end
        else
        begin
          if (!q.data_on && f_out_valid)
          begin
            f_pop        = 1'b1;
            n.data_on    = 1'b1;
            n.card_drive = 1'b1;
            n.card_dout  = q.ch[q.cur].ctl[`DMH_CTL_WORD] ? f_dout
                         : {8'h00, q.ch[q.cur].addr[0] ? f_dout[7:0] : f_dout[15:8]};
          end
          if (q.data_on && !card_data_valid_n_i)
            n.st = dmh_pkg::dmh_st_end;
          else if (q.tmr >= CARD_TO - 8'h01)
            n = bus_error(n);
        end
      end
      dmh_pkg::dmh_st_mem:
      begin
        n.tmr = q.tmr + 8'h01;
        if (!q.ch[q.cur].ctl[`DMH_CTL_OUT])
        begin
          if (!q.data_on && f_out_valid)
          begin
            f_pop           = 1'b1;
            n.data_on       = 1'b1;
            n.bus.data_oe_n = 1'b0;
            n.bus.data      = q.fold ? {f_dout[7:0], f_dout[7:0]} : f_dout;
            n               = set_lanes(n);
          end
          if (q.data_on && !memory_ack_n_i)
            n.st = dmh_pkg::dmh_st_end;
          else if (q.tmr >= MEM_TO - 8'h01)
            n = bus_error(n);
        end
        else
        begin
          if (!memory_ack_n_i && f_in_ready)
          begin
            f_push      = 1'b1;
            f_din       = bus_data_i;
            n.bus.uds_n = 1'b1;
            n.bus.lds_n = 1'b1;
            n.tmr       = 8'h00;
            n.st        = dmh_pkg::dmh_st_card;
          end
          else if (q.tmr >= MEM_TO - 8'h01)
            n = bus_error(n);
        end
      end
      dmh_pkg::dmh_st_end:
      begin
        n = end_cycle(n);
        n.ch[q.cur].addr = q.ch[q.cur].addr
                         + (q.ch[q.cur].ctl[`DMH_CTL_WORD] ? 32'h0000_0002 : 32'h0000_0001);
        n.ch[q.cur].cnt  = q.ch[q.cur].cnt - 16'h0001;
        n.tmr            = 8'h00;
        if (q.ch[q.cur].cnt == 16'h0000)
        begin
          n = release_bus(n);
          n.ch[q.cur].arm  = 1'b0;
          n.ch[q.cur].intr = q.ch[q.cur].intr || q.ch[q.cur].ctl[`DMH_CTL_IE];
        end
        else
          n.st = dmh_pkg::dmh_st_hold;
      end
      dmh_pkg::dmh_st_hold:
      begin
        n.tmr = q.tmr + 8'h01;
        if (n.ch[q.cur].arm && !xfer_request_n_i[q.cur])
          n = begin_cycle(n);
        else if (!n.ch[q.cur].arm
                 || q.tmr >= (q.ch[q.cur].ctl[`DMH_CTL_PRI] ? WIN1 : WIN0) - 8'h01)
          n = release_bus(n);
      end
      default:
        n = release_bus(n);
    endcase

    // Abort from the host overrides the engine
    if (kill)
    begin
      n       = release_bus(n);
      n.ch[q.cur].arm = 1'b0;
      f_push  = 1'b0;
      f_pop   = 1'b0;
      f_flush = 1'b1;
    end
    if (n.st == dmh_pkg::dmh_st_idle && q.st != dmh_pkg::dmh_st_idle)
      f_flush = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q               <= '0;
      q.st            <= dmh_pkg::dmh_st_idle;
      q.bus.drive_n   <= 1'b1;
      q.bus.as_n      <= 1'b1;
      q.bus.rnw       <= 1'b1;
      q.bus.uds_n     <= 1'b1;
      q.bus.lds_n     <= 1'b1;
      q.bus.long_n    <= 1'b1;
      q.bus.data_oe_n <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
        q.ch[i].addr <= `DMH_ADDR_RST;
        q.ch[i].cnt  <= `DMH_CNT_RST;
        q.ch[i].ctl  <= `DMH_CTL_RST;
      end
    end
    else
      q <= n;
  end

  dmh_fifo #(
    .W     (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (f_flush),
    .in_valid_i  (f_push),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_din),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_dout)
  );

  // Interrupt shows only once the bus is given back
  assign irq_o            = (q.ch[0].intr || q.ch[1].intr) && !q.own;
  assign host_rsp_o       = q.rsp;
  assign bus_o            = q.bus;
  assign card_data_o      = q.card_dout;
  assign card_data_oe_n_o = !q.card_drive;
  assign fold_n_o         = !(q.fold && |q.grant);
  assign done_n_o         = !(q.done && |q.grant);
endmodule

// ==== verification/dmh_ctrl_assertions.sv ====
// Port-level checker for the DMA controller
`timescale 1ns/10ps
`include "dmh_params.svh"
module dmh_ctrl_assertions (
  // Clock and reset
  input wire logic                   mclk_i,
  input wire logic                   rst_n_i,
  // Host side
  input wire dmh_pkg::dmh_host_req_t host_req_i,
  input wire dmh_pkg::dmh_host_rsp_t host_rsp_o,
  input wire logic                   irq_o,
  // Bus and card side
  input wire dmh_pkg::dmh_bus_out_t  bus_o,
  input wire logic [1:0]             xfer_grant_n_o,
  input wire logic                   card_data_valid_n_i,
  input wire logic                   card_data_oe_n_o,
  input wire logic                   fold_n_o,
  input wire logic                   done_n_o
);
  logic [7:0] wait_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles an input transfer has waited for card data
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wait_q <= 8'h00;
    else if (&xfer_grant_n_o || !card_data_valid_n_i || bus_o.rnw)
      wait_q <= 8'h00;
    else
      wait_q <= wait_q + 8'h01;
  end
  sequence s_release;
    $rose(&xfer_grant_n_o);
  endsequence
  sequence s_abort0;
    host_req_i.req && host_req_i.rnw && host_req_i.addr == `DMH_CH0_BASE
      && !host_req_i.uds_n && !host_req_i.lds_n && !xfer_grant_n_o[0];
  endsequence
  property p_flag;
    !(&xfer_grant_n_o) && !(&$past(xfer_grant_n_o))
      |-> $stable(fold_n_o) && $stable(done_n_o);
  endproperty
  property p_release;
    s_release |-> fold_n_o && done_n_o && bus_o.as_n;
  endproperty
  property p_ack;
    host_rsp_o.ack == $past(host_req_i.req);
  endproperty
  property p_refuse;
    host_req_i.req && host_req_i.addr[31:4] != 28'h0050000 |=> host_rsp_o.err;
  endproperty
  property p_abort;
    s_abort0 |=> xfer_grant_n_o[0] && bus_o.as_n;
  endproperty
  property p_irq;
    irq_o |-> &xfer_grant_n_o;
  endproperty
  property p_card_to;
    wait_q <= 8'd127;
  endproperty
  property p_dir;
    !card_data_oe_n_o |-> bus_o.rnw;
  endproperty
  a_flag: assert property (p_flag) else $error("fold or done moved within grant");
  a_release: assert property (p_release) else $error("flags held after grant");
  a_ack: assert property (p_ack) else $error("host ack timing");
  a_refuse: assert property (p_refuse) else $error("unmapped access taken");
  a_abort: assert property (p_abort) else $error("abort kept bus");
  a_irq: assert property (p_irq) else $error("irq while owning bus");
  a_card_to: assert property (p_card_to) else $error("card wait unbounded");
  a_dir: assert property (p_dir) else $error("card driven on input");
endmodule
bind dmh_ctrl dmh_ctrl_assertions u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .host_req_i(host_req_i), .host_rsp_o(host_rsp_o),
  .irq_o(irq_o), .bus_o(bus_o), .xfer_grant_n_o(xfer_grant_n_o),
  .card_data_valid_n_i(card_data_valid_n_i), .card_data_oe_n_o(card_data_oe_n_o),
  .fold_n_o(fold_n_o), .done_n_o(done_n_o));

// ==== verification/dmh_card_model.sv ====
// I/O card and memory facing the DMA controller
`timescale 1ns/10ps
module dmh_card_model (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  // Requesting channels, card delay (FF never answers)
  input  wire logic [1:0]            ask_i,
  input  wire logic [7:0]            dly_i,
  // Controller outputs
  input  wire logic [1:0]            grant_n_i,
  input  wire dmh_pkg::dmh_bus_out_t bus_i,
  input  wire logic                  card_oe_n_i,
  input  wire logic                  fold_n_i,
  input  wire logic                  done_n_i,
  // Card and memory answers
  output logic [1:0]                 request_n_o,
  output logic                       valid_n_o,
  output logic [15:0]                data_o,
  output logic                       bus_grant_o,
  output logic                       mem_ack_n_o,
  output logic [15:0]                mem_data_o,
  // Memory writes seen
  output logic [15:0]                wr_cnt_o,
  output logic [31:0]                wr_addr_o,
  output logic [15:0]                wr_data_o,
  // Fold and final-transfer pulses seen by the card
  output logic [7:0]                 done_cnt_o,
  output logic [7:0]                 fold_cnt_o
);
  logic [7:0] wait_q;
  logic [1:0] flag_q;
  logic [7:0] seq_q;
  logic       sel;
  assign sel         = !bus_i.as_n && !(bus_i.uds_n && bus_i.lds_n);
  assign request_n_o = ~ask_i;
  // Released lines show the inverse so a stale value never passes
  assign data_o      = valid_n_o ? ~{8'hA5, seq_q} : {8'hA5, seq_q};
  assign mem_data_o  = mem_ack_n_o ? 16'hA5FF : 16'h5A00;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_q      <= 8'h00;
      seq_q       <= 8'h00;
      valid_n_o   <= 1'b1;
      bus_grant_o <= 1'b0;
      mem_ack_n_o <= 1'b1;
      wr_cnt_o    <= 16'h0000;
      wr_addr_o   <= 32'h0000_0000;
      wr_data_o   <= 16'h0000;
      flag_q      <= 2'b00;
      done_cnt_o  <= 8'h00;
      fold_cnt_o  <= 8'h00;
    end
    else
    begin
      bus_grant_o <= bus_i.req;
      mem_ack_n_o <= !sel;
      // Each done pulse is what the card would turn into its own interrupt
      flag_q <= {!fold_n_i, !done_n_i};
      if (flag_q[0] && done_n_i)
        done_cnt_o <= done_cnt_o + 8'h01;
      if (flag_q[1] && fold_n_i)
        fold_cnt_o <= fold_cnt_o + 8'h01;
      if (mem_ack_n_o && sel && !bus_i.rnw)
      begin
        wr_cnt_o  <= wr_cnt_o + 16'h0001;
        wr_addr_o <= bus_i.addr;
        wr_data_o <= bus_i.data;
      end
      if (&grant_n_i)
      begin
        valid_n_o <= 1'b1;
        wait_q    <= 8'h00;
        if (!valid_n_o)
          seq_q <= seq_q + 8'h01;
      end
      else if (dly_i != 8'hFF && (!bus_i.rnw || !card_oe_n_i))
      begin
        wait_q <= wait_q + 8'h01;
        if (wait_q >= dly_i)
          valid_n_o <= 1'b0;
      end
    end
  end
endmodule

// ==== verification/dmh_ctrl_tb.sv ====
// Testbench for the DMA controller registers and transfers
`timescale 1ns/10ps
`include "dmh_params.svh"
module dmh_ctrl_tb;
  logic                   mclk_i;
  logic                   rst_n_i;
  dmh_pkg::dmh_host_req_t hreq;
  dmh_pkg::dmh_host_rsp_t hrsp;
  dmh_pkg::dmh_bus_out_t  bus;
  logic                   irq, gnt, mack_n, vld_n, coe_n, fold_n, done_n;
  logic [1:0]             req_n, gnt_n, ask;
  logic [7:0]             dly, done_cnt, fold_cnt;
  logic [15:0]            mdata, cdi, cdo, wr_cnt, wr_data, v;
  logic [31:0]            wr_addr;
  int                     miscompares = 0;
  int                     tests_run = 0;
  localparam logic [31:0] c0 = `DMH_CH0_BASE;
  localparam logic [31:0] c1 = `DMH_CH1_BASE;
  dmh_ctrl dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .host_req_i(hreq), .host_rsp_o(hrsp), .irq_o(irq),
    .bus_grant_i(gnt), .memory_ack_n_i(mack_n), .bus_data_i(mdata), .bus_o(bus),
    .xfer_request_n_i(req_n), .xfer_grant_n_o(gnt_n), .card_data_valid_n_i(vld_n),
    .card_data_i(cdi), .card_data_o(cdo), .card_data_oe_n_o(coe_n), .fold_n_o(fold_n),
    .done_n_o(done_n));
  dmh_card_model card_m (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ask_i(ask), .dly_i(dly), .grant_n_i(gnt_n),
    .bus_i(bus), .card_oe_n_i(coe_n), .request_n_o(req_n), .valid_n_o(vld_n),
    .data_o(cdi), .bus_grant_o(gnt), .mem_ack_n_o(mack_n), .mem_data_o(mdata),
    .wr_cnt_o(wr_cnt), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .fold_n_i(fold_n),
    .done_n_i(done_n), .done_cnt_o(done_cnt), .fold_cnt_o(fold_cnt));
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Lanes are {upper, lower} strobes, active low
  task automatic acc(input logic rnw, input logic [31:0] a, input logic [15:0] wd,
                     input logic [1:0] ln, input logic er, output logic [15:0] rd);
    @(posedge mclk_i);
    hreq <= '{1'b1, rnw, a, ln[1], ln[0], wd};
    @(posedge mclk_i);
    hreq.req <= 1'b0;
    #1;
    rd = hrsp.rdata;
    chk("ack", 1'b1, hrsp.ack);
    chk("err", er, hrsp.err);
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [15:0] e);
    acc(1'b1, a, 16'h0000, 2'b00, 1'b0, v);
    chk(n, e, v);
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    acc(1'b0, a, d, 2'b00, 1'b0, v);
  endtask
  task automatic card(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    ask <= a;
    dly <= d;
  endtask
  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim)
    begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    chk("irq", 1'b1, irq);
  endtask
  initial
  begin
    hreq = '0;
    rst_n_i = 1'b0;
    ask = 2'b00;
    dly = 8'h00;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rdc("count0", c0 + 4, 16'h0000);
    rdc("status0", c0 + 6, 16'h0000);
    acc(1'b1, 32'h0050_0010, 16'h0000, 2'b00, 1'b1, v);
    acc(1'b1, c0 + 4, 16'h0000, 2'b10, 1'b1, v);
    acc(1'b1, c0 + 7, 16'h0000, 2'b10, 1'b0, v);
    wr(c1 + 4, 16'h1234);
    rdc("count1", c1 + 4, 16'h1234);
    rdc("count0", c0 + 4, 16'h0000);
    // Word input burst of three on channel 0, priority set
    wr(c0, 16'h0000);
    wr(c0 + 2, 16'h1000);
    rdc("addr_lo", c0 + 2, 16'h0000);
    wr(c0 + 4, 16'h0002);
    wr(c0 + 6, 16'h000B);
    card(2'b01, 8'h01);
    wait_irq(600);
    chk("writes", 32'd3, wr_cnt);
    chk("last_addr", 32'h0000_1004, wr_addr);
    chk("last_data", 32'h0000_A502, wr_data);
    rdc("count0", c0 + 4, 16'hFFFF);
    chk("done", 32'd1, done_cnt);
    rdc("status0", c0 + 6, 16'h0202);
    rdc("clear0", c0, 16'h0000);
    rdc("status0", c0 + 6, 16'h0000);
    chk("irq_off", 1'b0, irq);
    // Silent card on channel 1 ends in a bus error
    wr(c1 + 4, 16'h0005);
    wr(c1 + 6, 16'h0003);
    card(2'b10, 8'hFF);
    wait_irq(300);
    rdc("count1", c1 + 4, 16'h0005);
    rdc("status1", c1 + 6, 16'h0202);
    chk("writes", 32'd3, wr_cnt);
    chk("done", 32'd1, done_cnt);
    rdc("clear1", c1, 16'h0000);
    // Output on channel 0 aborted mid-transfer, then resumed
    wr(c0 + 2, 16'h2000);
    wr(c0 + 4, 16'h0003);
    card(2'b01, 8'hFF);
    wr(c0 + 6, 16'h000F);
    repeat (20) @(posedge mclk_i);
    rdc("abort0", c0, 16'h0000);
    chk("grant", 32'd3, gnt_n);
    rdc("count0", c0 + 4, 16'h0003);
    rdc("status0", c0 + 6, 16'h0000);
    card(2'b01, 8'h02);
    wr(c0 + 6, 16'h000F);
    wait_irq(900);
    rdc("count0", c0 + 4, 16'hFFFF);
    chk("card_data", 32'h0000_5A00, cdo);
    chk("done", 32'd2, done_cnt);
    rdc("clear0", c0, 16'h0000);
    // Byte input at an even address lands on both lanes
    wr(c1 + 2, 16'h3000);
    wr(c1 + 4, 16'h0000);
    wr(c1 + 6, 16'h0001);
    card(2'b10, 8'h01);
    wait_irq(300);
    chk("byte_data", 32'h0000_0707, wr_data);
    chk("byte_addr", 32'h0000_3000, wr_addr);
    rdc("clear1", c1, 16'h0000);
    chk("fold", 32'd1, fold_cnt);
    chk("done", 32'd3, done_cnt);
    // Odd byte on the lower lane; a withdrawn request gives the bus up
    wr(c1 + 4, 16'h0001);
    wr(c1 + 6, 16'h0001);
    card(2'b10, 8'h01);
    wait (wr_cnt == 16'h0005);
    card(2'b00, 8'h01);
    repeat (6) @(posedge mclk_i);
    chk("bus_req", 32'd0, bus.req);
    chk("odd_data", 32'h0000_A508, wr_data);
    chk("odd_addr", 32'h0000_3001, wr_addr);
    rdc("status1", c1 + 6, 16'h0101);
    rdc("count1", c1 + 4, 16'h0000);
    card(2'b10, 8'h01);
    wait_irq(300);
    chk("fold_data", 32'h0000_0909, wr_data);
    rdc("count1", c1 + 4, 16'hFFFF);
    chk("done", 32'd4, done_cnt);
    chk("fold", 32'd2, fold_cnt);
    final_report;
  end
  initial
  begin
    repeat (6000) @(posedge mclk_i);
    miscompares++;
    final_report;
  end
endmodule
